// File: inc/fer_pkg.sv
/*
 fer_pkg: register offsets, field positions, reset values and class codes
 for the floating-point exception recorder.
 assumes: 32-bit axi4-lite register bus, one 40 MHz clock.
*/
`default_nettype none
package fer_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CAUSE = 8'h00; // fp_exception_cause_reg
	localparam logic [7:0] OFS_UCTL  = 8'h04; // fp_user_control_reg
	localparam logic [7:0] OFS_USTAT = 8'h08; // fp_user_status_reg
	localparam logic [7:0] OFS_SRC1  = 8'h0C; // src1_low_reg
	localparam logic [7:0] OFS_SRC2  = 8'h10; // src2_low_reg
	localparam logic [7:0] OFS_OPTYP = 8'h14; // precise_op_type_reg
	localparam logic [7:0] OFS_UNIT  = 8'h18; // unit state, fpu_disable_flag
	localparam logic [7:0] OFS_SXP   = 8'h1C; // shadow_exec_pointer
	localparam logic [7:0] OFS_TOP   = 8'h20; // highest ranked cause
	// cause bit positions
	localparam int CB_CONV = 7; // conv_overflow_cause
	localparam int CB_UNIM = 6; // unimpl_opcode_cause
	localparam int CB_PRIV = 4; // privilege_violation_cause, reserved_operand_cause
	localparam int CB_DVZ  = 3; // zero_divisor_cause
	localparam int DIS_BIT = 3; // fpu_disable_bit in unit register
	// writable masks and reset values
	localparam logic [31:0] UCTL_MASK  = 32'h0000C01F;
	localparam logic [31:0] USTAT_MASK = 32'h0000001F;
	localparam logic [31:0] REG_RST    = 32'h00000000;
	localparam logic [11:0] VEC_PRECISE = 12'h390; // precise vector offset
	localparam int CONV_EXP_LIM = 30; // conversion overflow exponent
	localparam logic [5:0] CR_USTAT = 6'h3E; // user status register number
	localparam logic [5:0] CR_UCTL  = 6'h3F; // user control register number
	// dispatched instruction class codes
	localparam logic [2:0] CL_NOP   = 3'h0;
	localparam logic [2:0] CL_ARITH = 3'h1;
	localparam logic [2:0] CL_CONV  = 3'h2;
	localparam logic [2:0] CL_IMUL  = 3'h3;
	localparam logic [2:0] CL_IDIV  = 3'h4;
	localparam logic [2:0] CL_CTRL  = 3'h5;
	localparam logic [2:0] CL_UNIM  = 3'h6;
	// run state of the unit
	typedef enum logic {ST_RUN = 1'b0, ST_FROZEN = 1'b1} fer_state_t;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
endpackage
`default_nettype wire

// File: rtl/fer_detect.sv
/*
 fer_detect: combinational detection of precise exception conditions
 for one dispatched instruction.
 assumes: dispatch inputs are stable in the cycle they are offered.
*/
`timescale 1ns/1ps
`default_nettype none
module fer_detect
	import fer_pkg::*;
(
	input  wire logic        valid,    // instruction offered
	input  wire logic [2:0]  cls,      // instruction class
	input  wire logic        frozen,   // unit disabled
	input  wire logic        sgn,      // signed divide
	input  wire logic [31:0] src1,     // source 1 operand
	input  wire logic [31:0] src2,     // source 2 operand
	input  wire logic [11:0] exp,      // signed unbiased exponent
	input  wire logic        rsvd,     // reserved operand seen
	input  wire logic        fdz,      // fp divisor is zero
	input  wire logic        user,     // user mode
	input  wire logic [5:0]  creg,     // control register number
	output logic      [7:0]  cause,    // cause bits to load
	output logic             fp_exc,   // fp precise exception
	output logic             dis_exc,  // unit-disabled exception
	output logic             idiv_err, // integer divide error
	output logic             sb_set,   // set destination scoreboard
	output logic             done      // accepted, no exception
);
	// class decode; unimplemented ops count as unit work while frozen
	wire unit_ins = (cls == CL_ARITH) | (cls == CL_CONV) | (cls == CL_IMUL) | (cls == CL_IDIV);
	wire ctrl_ins = valid & (cls == CL_CTRL);
	wire live     = valid & ~frozen;
	wire priv     = ctrl_ins & user & (creg != CR_USTAT) & (creg != CR_UCTL);
	wire unim     = live & (cls == CL_UNIM);
	// both sides signed: a negative exponent must not compare as a huge one
	wire conv_ovf = live & (cls == CL_CONV) & ($signed(exp) >= $signed(12'(CONV_EXP_LIM)));
	wire rop      = live & ((cls == CL_ARITH) | (cls == CL_CONV)) & rsvd;
	wire dvz      = live & (cls == CL_ARITH) & fdz;
	// several causes may coexist; fer_top ranks them for OFS_TOP
	assign cause    = {conv_ovf, unim, 1'b0, priv | rop, dvz, 3'h0};
	assign fp_exc   = |cause;
	assign dis_exc  = valid & frozen & (unit_ins | (cls == CL_UNIM));
	assign idiv_err = live & (cls == CL_IDIV) & ~fp_exc
		& ((src2 == 32'h00000000) | (sgn & (src1[31] | src2[31])));
	// unimplemented op on a running unit leaves scoreboard alone
	assign sb_set   = (fp_exc & ~unim) | dis_exc | idiv_err;
	assign done     = ((live & unit_ins) | ctrl_ins) & ~fp_exc & ~idiv_err;
endmodule // fer_detect
`default_nettype wire

// File: rtl/fer_top.sv
/*
 fer_top: fp exception recorder. detects precise exceptions on dispatch,
 loads the cause register, freezes the unit, reports to the instruction
 unit, saves operands; registers on an axi4-lite slave.
 assumes: one clock, dispatch synchronous, rte_req pulses on restart.
*/
`timescale 1ns/1ps
`default_nettype none
module fer_top
	import fer_pkg::*;
(
	input  wire logic        mclk,       // 40 MHz clock
	input  wire logic        arst_n,     // async reset, active low
	input  wire logic        disp_valid, // instruction dispatched
	input  wire logic [2:0]  disp_class, // instruction class
	input  wire logic        disp_sgn,   // signed divide
	input  wire logic [31:0] disp_src1,  // source 1 low word
	input  wire logic [31:0] disp_src2,  // source 2 low word
	input  wire logic [11:0] disp_exp,   // convert exponent
	input  wire logic        disp_rsvd,  // reserved operand
	input  wire logic        disp_fdz,   // fp divisor zero
	input  wire logic        disp_user,  // user mode
	input  wire logic [5:0]  disp_creg,  // control register number
	input  wire logic [10:0] disp_op,    // instruction bits 15..5
	input  wire logic [4:0]  disp_dest,  // destination register
	input  wire logic [31:0] disp_ip,    // instruction address
	input  wire logic        rte_req,    // restart from exception
	output logic             exc_q,      // exception to instruction unit
	output logic             exc_div_q,  // exception is divide error
	output logic [11:0]      exc_vec_q,  // vector offset
	output logic             squash_q,   // drop faulting instruction
	output logic             sb_set_q,   // set scoreboard bit
	output logic [4:0]       sb_dest_q,  // scoreboard register
	output logic             done_q,     // instruction accepted
	output logic             frozen_q,   // unit frozen
	output logic             hdl_en_q,   // user handler enabled
	input  wire logic [7:0]  awaddr,     // write address
	input  wire logic        awvalid,    // write address valid
	output logic             awready,    // write address ready
	input  wire logic [31:0] wdata,      // write data
	input  wire logic [3:0]  wstrb,      // write byte enables
	input  wire logic        wvalid,     // write data valid
	output logic             wready,     // write data ready
	output logic [1:0]       bresp,      // write response
	output logic             bvalid,     // write response valid
	input  wire logic        bready,     // write response ready
	input  wire logic [7:0]  araddr,     // read address
	input  wire logic        arvalid,    // read address valid
	output logic             arready,    // read address ready
	output logic [31:0]      rdata,      // read data
	output logic [1:0]       rresp,      // read response
	output logic             rvalid,     // read data valid
	input  wire logic        rready      // read data ready
);
	// byte-lane merge for partial writes
	function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
		begin
			if (s[i])
				r[8*i +: 8] = n[8*i +: 8];
		end
		return r;
	endfunction

	// register map hit test, shared by read and write decode
	function automatic logic mapped(input logic [7:0] a);
		return (a[7:2] <= OFS_TOP[7:2]);
	endfunction

	// state
	fer_state_t  st_q;         // run or frozen, fpu_disable_bit
	logic [7:0]  cause_q;      // fp_exception_cause_reg
	logic [31:0] uctl_q;       // fp_user_control_reg
	logic [31:0] ustat_q;      // fp_user_status_reg
	logic [31:0] src1_q;       // src1_low_reg
	logic [31:0] src2_q;       // src2_low_reg
	logic [15:0] optyp_q;      // precise_op_type_reg
	logic [31:0] sxp_q;        // shadow_exec_pointer
	logic [7:0]  awa_q;        // held write address
	logic [31:0] wd_q;         // held write data
	logic [3:0]  ws_q;         // held write strobes
	logic        aw_have_q;    // write address held
	logic        w_have_q;     // write data held

	// detector results
	logic [7:0]  cause_w;      // cause bits
	logic        fp_exc_w;     // fp precise exception
	logic        dis_exc_w;    // unit disabled exception
	logic        idiv_w;       // divide error
	logic        sb_w;         // scoreboard set
	logic        done_w;       // clean completion

	fer_detect u_det (
		.valid    (disp_valid),
		.cls      (disp_class),
		.frozen   (st_q == ST_FROZEN),
		.sgn      (disp_sgn),
		.src1     (disp_src1),
		.src2     (disp_src2),
		.exp      (disp_exp),
		.rsvd     (disp_rsvd),
		.fdz      (disp_fdz),
		.user     (disp_user),
		.creg     (disp_creg),
		.cause    (cause_w),
		.fp_exc   (fp_exc_w),
		.dis_exc  (dis_exc_w),
		.idiv_err (idiv_w),
		.sb_set   (sb_w),
		.done     (done_w)
	);

	// any event that reaches the instruction unit
	wire any_exc = fp_exc_w | dis_exc_w | idiv_w;
	// operands captured for fp precise and divide errors alike
	wire cap     = fp_exc_w | idiv_w;
	// size fields keep only their low bit
	wire [10:0] op_clr = disp_op & 11'h7D5;

	// write channel decode
	wire       wr_go   = aw_have_q & w_have_q & ~bvalid; // both halves present
	wire       wr_hit  = mapped(awa_q);
	wire       wr_cau  = wr_go & (awa_q == OFS_CAUSE);
	wire       wr_uctl = wr_go & (awa_q == OFS_UCTL);
	wire       wr_ust  = wr_go & (awa_q == OFS_USTAT);
	wire       wr_unit = wr_go & (awa_q == OFS_UNIT);
	wire [31:0] unit_r = {28'h0000000, (st_q == ST_FROZEN), 3'h0};
	wire [31:0] unit_w = mrg(unit_r, wd_q, ws_q);
	wire [31:0] cau_w  = mrg({24'h000000, cause_q}, wd_q, ws_q);

	// highest ranked cause, 7 first
	logic [3:0] top_w;
	always_comb
	begin
		top_w = 4'hF; // none set
		for (int i = 0; i < 8; i++)
		begin
			if (cause_q[i])
				top_w = 4'(i);
		end
	end

	// read decode
	wire        rd_go  = arvalid & arready;
	wire        rd_hit = mapped(araddr);
	wire [31:0] rd_val =
		(araddr == OFS_CAUSE) ? {24'h000000, cause_q} :
		(araddr == OFS_UCTL)  ? uctl_q :
		(araddr == OFS_USTAT) ? ustat_q :
		(araddr == OFS_SRC1)  ? src1_q :
		(araddr == OFS_SRC2)  ? src2_q :
		(araddr == OFS_OPTYP) ? {16'h0000, optyp_q} :
		(araddr == OFS_UNIT)  ? unit_r :
		(araddr == OFS_SXP)   ? sxp_q :
		(araddr == OFS_TOP)   ? {28'h0000000, top_w} : 32'h00000000;

	// handler enable lookup: divide when the zero divisor cause is set, else invalid
	wire hdl_w = cause_w[CB_DVZ] ? uctl_q[3] : uctl_q[4];

	// run state; the exception's set wins over a restart or a write
	fer_state_t st_d;
	assign st_d = (fp_exc_w | idiv_w) ? ST_FROZEN :
		rte_req ? ST_RUN :
		wr_unit ? fer_state_t'(unit_w[DIS_BIT]) : st_q;

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			st_q <= ST_RUN;
		else
			st_q <= st_d;
	end

	// cause: hardware load beats software write; disabled trap skips it
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			cause_q <= REG_RST[7:0];
		else if (fp_exc_w)
			cause_q <= cause_w;
		else if (wr_cau)
			cause_q <= cau_w[7:0];
	end

	// user control and status stay software owned, live while frozen
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			uctl_q  <= REG_RST;
			ustat_q <= REG_RST;
		end
		else
		begin
			if (wr_uctl)
				uctl_q <= mrg(uctl_q, wd_q, ws_q) & UCTL_MASK;
			if (wr_ust)
				ustat_q <= mrg(ustat_q, wd_q, ws_q) & USTAT_MASK;
		end
	end

	// saved context of the faulting instruction
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			src1_q  <= REG_RST;
			src2_q  <= REG_RST;
			optyp_q <= REG_RST[15:0];
			sxp_q   <= REG_RST;
		end
		else if (cap)
		begin
			src1_q  <= disp_src1;
			src2_q  <= disp_src2;
			optyp_q <= {op_clr, disp_dest};
			sxp_q   <= disp_ip;
		end
	end

	// reports to the instruction and integer units; no result on a trap
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			exc_q     <= 1'b0;
			exc_div_q <= 1'b0;
			exc_vec_q <= 12'h000;
			squash_q  <= 1'b0;
			sb_set_q  <= 1'b0;
			sb_dest_q <= 5'h00;
			done_q    <= 1'b0;
			hdl_en_q  <= 1'b0;
		end
		else
		begin
			exc_q     <= any_exc;
			exc_div_q <= idiv_w;
			exc_vec_q <= (fp_exc_w | dis_exc_w) ? VEC_PRECISE : 12'h000;
			squash_q  <= fp_exc_w | idiv_w;
			sb_set_q  <= sb_w;
			sb_dest_q <= sb_w ? disp_dest : sb_dest_q;
			done_q    <= done_w;
			// bit 4 is shared: the control-access case and an unimplemented op have no handler
			hdl_en_q  <= fp_exc_w & ~cause_w[CB_UNIM] & (disp_class != CL_CTRL) ? hdl_w : 1'b0;
		end
	end
	assign frozen_q = (st_q == ST_FROZEN);

	// axi write channels: address and data taken in either order
	wire aw_have_d = (aw_have_q | (awvalid & awready)) & ~wr_go;
	wire w_have_d  = (w_have_q | (wvalid & wready)) & ~wr_go;
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awready   <= 1'b1;
			wready    <= 1'b1;
			awa_q     <= 8'h00;
			wd_q      <= 32'h00000000;
			ws_q      <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= RESP_OK;
		end
		else
		begin
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			awready   <= ~aw_have_d;
			wready    <= ~w_have_d;
			if (awvalid & awready)
				awa_q <= awaddr;
			if (wvalid & wready)
			begin
				wd_q <= wdata;
				ws_q <= wstrb;
			end
			if (wr_go)
			begin
				bvalid <= 1'b1;
				bresp  <= wr_hit ? RESP_OK : RESP_ERR;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end

	// axi read channel: one outstanding read, answer one cycle later
	wire rvalid_d = rd_go | (rvalid & ~rready);
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= RESP_OK;
		end
		else
		begin
			arready <= ~rvalid_d;
			rvalid  <= rvalid_d;
			if (rd_go)
			begin
				rdata <= rd_hit ? rd_val : 32'h00000000;
				rresp <= rd_hit ? RESP_OK : RESP_ERR;
			end
		end
	end

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	cause_load_a: assert property (fp_exc_w |=> exc_q && cause_q == $past(cause_w))
		else $error("cause not loaded on exception");
	freeze_a: assert property (fp_exc_w |=> frozen_q && squash_q && exc_vec_q == VEC_PRECISE)
		else $error("unit not frozen after exception");
	frozen_refuse_a: assert property (frozen_q && disp_valid && (disp_class == CL_ARITH || disp_class == CL_IMUL)
		|=> !done_q && exc_q)
		else $error("frozen unit ran an instruction");
	restart_a: assert property (rte_req && !fp_exc_w && !idiv_w |=> !frozen_q)
		else $error("restart did not resume");
	div_zero_a: assert property (disp_valid && !frozen_q && disp_class == CL_IDIV
		&& disp_src2 == 32'h00000000 |=> exc_div_q && sb_set_q)
		else $error("zero divisor not trapped");
	div_save_a: assert property (idiv_w |=> sxp_q == $past(disp_ip) && src2_q == $past(disp_src2)
		&& optyp_q[4:0] == $past(disp_dest))
		else $error("divide error context wrong");
	no_result_a: assert property (exc_q |-> !done_q)
		else $error("result written on exception");
	dis_cause_a: assert property (dis_exc_w && !wr_cau |=> $stable(cause_q) && exc_q)
		else $error("disabled trap changed cause");
	conv_bit_a: assert property (fp_exc_w && disp_class == CL_CONV && $signed(disp_exp) >= 12'sd30
		|=> cause_q[CB_CONV])
		else $error("conversion overflow bit missing");
	unimpl_a: assert property (disp_valid && !frozen_q && disp_class == CL_UNIM
		|=> cause_q == 8'h40 && !sb_set_q)
		else $error("unimplemented opcode handling wrong");
	cause_hold_a: assert property (!fp_exc_w && !wr_cau |=> $stable(cause_q))
		else $error("cause changed without cause");
endmodule // fer_top
`default_nettype wire

// File: tb/fer_iu_model.sv
/*
 fer_iu_model: instruction-unit side of the recorder, holding the
 destination scoreboard that the recorder marks and the handler clears.
 assumes: sb_set is a one-cycle pulse with sb_dest valid in that cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module fer_iu_model
	import fer_pkg::*;
(
	input  wire logic        mclk,    // clock
	input  wire logic        arst_n,  // async reset, active low
	input  wire logic        sb_set,  // mark request from recorder
	input  wire logic [4:0]  sb_dest, // register to mark
	input  wire logic        hdl_clr, // handler clears one bit
	input  wire logic [4:0]  clr_idx, // bit the handler clears
	output logic      [31:0] sb_q     // scoreboard bits
);
	// set after clear: a fresh mark must not be lost to a stale clear
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			sb_q <= 32'h00000000;
		else
		begin
			if (hdl_clr)
				sb_q[clr_idx] <= 1'b0;
			if (sb_set)
				sb_q[sb_dest] <= 1'b1;
		end
	end
endmodule // fer_iu_model
`default_nettype wire

// File: tb/testbench.sv
/*
 testbench: dispatch and axi4-lite sequences against fer_top.
 assumes: fer_pkg compiled first, dut answers dispatch one edge later.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
	import fer_pkg::*;
;
	typedef struct {logic [2:0] c; logic [11:0] x; logic r, z, u; logic [5:0] g; logic [7:0] k; logic s;} fer_case_t;
	logic mclk, arst_n, disp_valid, disp_sgn, disp_rsvd, disp_fdz, disp_user, rte_req;
	logic [2:0] disp_class;
	logic [31:0] disp_src1, disp_src2, disp_ip, wdata, rdata, d, sb_q;
	logic [11:0] disp_exp, exc_vec_q;
	logic [5:0] disp_creg;
	logic [10:0] disp_op;
	logic [4:0] disp_dest, sb_dest_q;
	logic exc_q, exc_div_q, squash_q, sb_set_q, done_q, frozen_q, hdl_en_q, hdl_clr;
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	int fails, checked, cyc;
	fer_case_t cs [8];

	fer_top dut_u (.mclk, .arst_n, .disp_valid, .disp_class, .disp_sgn, .disp_src1, .disp_src2, .disp_exp,
		.disp_rsvd, .disp_fdz, .disp_user, .disp_creg, .disp_op, .disp_dest, .disp_ip, .rte_req, .exc_q,
		.exc_div_q, .exc_vec_q, .squash_q, .sb_set_q, .sb_dest_q, .done_q, .frozen_q, .hdl_en_q, .awaddr,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready);
	// scoreboard owner on the far side
	fer_iu_model iu_u (.mclk, .arst_n, .sb_set(sb_set_q), .sb_dest(sb_dest_q), .hdl_clr,
		.clr_idx(disp_dest), .sb_q);

	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// hang guard: whole run needs well under this
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			fails++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask

	// write: address and data offered together, each dropped when taken
	task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		@(posedge mclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask

	// one-cycle dispatch, outputs looked at just after the answer edge
	task automatic dsp(input logic [2:0] c, input logic [11:0] x, input logic rv, z, u, input logic [5:0] g,
		input logic sg, input logic [31:0] s1, s2);
		@(posedge mclk);
		{disp_class, disp_exp, disp_rsvd, disp_fdz, disp_user, disp_creg} <= {c, x, rv, z, u, g};
		{disp_sgn, disp_src1, disp_src2} <= {sg, s1, s2};
		disp_valid <= 1'b1;
		@(posedge mclk);
		disp_valid <= 1'b0;
		#1;
	endtask

	// handler end: clear the mark, restart the unit
	task automatic restart();
		@(posedge mclk);
		rte_req <= 1'b1;
		hdl_clr <= 1'b1;
		@(posedge mclk);
		rte_req <= 1'b0;
		hdl_clr <= 1'b0;
		#1;
		chk(frozen_q, 1'b0);
		chk(sb_q, 32'h00000000);
	endtask

	function automatic logic [31:0] top_of(input logic [7:0] k);
		top_of = 32'h0000000F;
		for (int b = 0; b < 8; b++)
			if (k[b]) top_of = b;
	endfunction

	task automatic wrap_up();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		{disp_valid, disp_class, disp_sgn, disp_src1, disp_src2, disp_exp, disp_rsvd, disp_fdz} = '0;
		{disp_user, disp_creg, rte_req, hdl_clr, awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
		disp_op = 11'h7FF;
		disp_dest = 5'h09;
		disp_ip = 32'h00001234;
		wstrb = 4'hF;
		fails = 0;
		checked = 0;
		cyc = 0;
		arst_n = 1'b0;
		// class, exponent, reserved, fdz, user, creg, cause, scoreboard
		cs[0] = '{CL_ARITH, 12'h000, 0, 1, 0, 6'h00, 8'h08, 1};
		cs[1] = '{CL_CONV, 12'h01E, 0, 0, 0, 6'h00, 8'h80, 1};
		cs[2] = '{CL_CONV, 12'h01D, 0, 0, 0, 6'h00, 8'h00, 0};
		cs[3] = '{CL_UNIM, 12'h000, 0, 0, 0, 6'h00, 8'h40, 0};
		cs[4] = '{CL_CTRL, 12'h000, 0, 0, 1, 6'h05, 8'h10, 1};
		cs[5] = '{CL_CTRL, 12'h000, 0, 0, 1, CR_UCTL, 8'h00, 0};
		cs[6] = '{CL_ARITH, 12'h000, 1, 0, 0, 6'h00, 8'h10, 1};
		cs[7] = '{CL_ARITH, 12'h000, 1, 1, 0, 6'h00, 8'h18, 1};
		repeat (20) @(posedge mclk);
		arst_n <= 1'b1;
		// reset values, one word per register
		for (int i = 0; i < 9; i++)
		begin
			axr(8'(4 * i), d, r);
			chk(d, (i == 8) ? 32'h0000000F : REG_RST);
		end
		axw(OFS_UCTL, 32'hFFFFFFFF, r);
		axr(OFS_UCTL, d, r);
		chk(d, UCTL_MASK);
		axw(OFS_SRC1, 32'h55AA55AA, r);
		axr(OFS_SRC1, d, r);
		chk(d, 32'h00000000);
		axw(8'h24, 32'h00000001, r);
		chk(r, RESP_ERR);
		axr(8'h24, d, r);
		chk(d, 32'h00000000);
		chk(r, RESP_ERR);
		axw(OFS_UNIT, 32'h00000008, r);
		chk(frozen_q, 1'b1);
		axw(OFS_UNIT, 32'h00000000, r);
		chk(frozen_q, 1'b0);
		axw(OFS_UCTL, 32'h00000008, r);
		// every precise cause alone, reserved operand with zero divisor combined
		for (int i = 0; i < 8; i++)
		begin
			dsp(cs[i].c, cs[i].x, cs[i].r, cs[i].z, cs[i].u, cs[i].g, 1'b0, 32'h1, 32'h1);
			chk({exc_q, done_q}, {cs[i].k != 0, cs[i].k == 0});
			chk(sb_set_q, cs[i].s);
			if (cs[i].k != 0)
			begin
				chk({squash_q, exc_vec_q}, {1'b1, VEC_PRECISE});
				axr(OFS_CAUSE, d, r);
				chk(d, cs[i].k);
				axr(OFS_TOP, d, r);
				chk(d, top_of(cs[i].k));
				// handler with no user routine records the accrued flag itself
				if (cs[i].k[CB_CONV] | cs[i].k[CB_DVZ])
				begin
					axw(OFS_USTAT, cs[i].k[CB_CONV] ? 32'h00000010 : 32'h00000008, r);
					axr(OFS_USTAT, d, r);
					chk(d, cs[i].k[CB_CONV] ? 32'h00000010 : 32'h00000008);
				end
				chk(frozen_q, 1'b1);
				chk(sb_q[disp_dest], cs[i].s);
				restart();
			end
		end
		// negative exponent stays below the overflow threshold
		dsp(CL_CONV, 12'hFE2, 0, 0, 0, 6'h00, 0, 32'h1, 32'h1);
		chk({exc_q, done_q}, 2'b01);
		// frozen unit: unit ops trap, control ops pass
		dsp(CL_ARITH, 12'h000, 0, 1, 0, 6'h00, 0, 32'h1, 32'h1);
		chk(hdl_en_q, 1'b1);
		dsp(CL_IMUL, 12'h000, 0, 0, 0, 6'h00, 0, 32'h1, 32'h1);
		chk({exc_q, exc_vec_q, done_q, squash_q}, {1'b1, VEC_PRECISE, 2'b00});
		axr(OFS_CAUSE, d, r);
		chk(d, 32'h00000008);
		dsp(CL_CTRL, 12'h000, 0, 0, 1, CR_USTAT, 0, 32'h1, 32'h1);
		chk({exc_q, done_q}, 2'b01);
		axw(OFS_USTAT, 32'hFFFFFFFF, r);
		axr(OFS_USTAT, d, r);
		chk(d, USTAT_MASK);
		restart();
		dsp(CL_ARITH, 12'h000, 0, 0, 0, 6'h00, 0, 32'h1, 32'h1);
		chk({exc_q, done_q}, 2'b01);
		// divide error: zero divisor, signed negative, then unsigned clean
		disp_dest <= 5'h11;
		dsp(CL_IDIV, 12'h000, 0, 0, 0, 6'h00, 0, 32'h00000064, 32'h00000000);
		chk({exc_q, exc_div_q, squash_q, sb_set_q, done_q}, 5'b11110);
		chk(sb_dest_q, 5'h11);
		axr(OFS_SRC1, d, r);
		chk(d, 32'h00000064);
		axr(OFS_SRC2, d, r);
		chk(d, 32'h00000000);
		axr(OFS_OPTYP, d, r);
		chk(d, {16'h0000, disp_op & ~11'h02A, 5'h11});
		axr(OFS_SXP, d, r);
		chk(d, disp_ip);
		restart();
		dsp(CL_IDIV, 12'h000, 0, 0, 0, 6'h00, 1, 32'hFFFFFFFB, 32'h00000003);
		chk({exc_q, exc_div_q}, 2'b11);
		restart();
		dsp(CL_IDIV, 12'h000, 0, 0, 0, 6'h00, 0, 32'hFFFFFFFB, 32'h00000003);
		chk({exc_q, done_q}, 2'b01);
		wrap_up();
	end
endmodule // testbench
`default_nettype wire
